// File: tai_alarm_integrator.sv
// Purpose: T1 carrier failure alarm integrator with register slave.
// Assumes: Framer status and line data are on clk_i; no syncing.
// Notes: Windows are free running; alarm updates happen at window ends.
// Contract
// - Global E1 select holds all but the bus handshake and read data in reset.
// - ESF bit chooses ESF, else frame bits.
// - Frame bits decode SF, T1DM, SLC, alternate.
// - Alternate mode: normal Red, T1DM Yellow.
// - ESF with 00 uses full-rate link code.
// - Fast mode clears Red within 120 ms.
// - Fast mode clears BLUE_ALARM_STATE within 180 ms.
// - Without fast mode, slower deassertion applies.
// - Each alarm has its own interrupt enable.
// - Reset clears all three interrupt enables.
// - Status holds change flags and live states.
// - Reading status clears flags and interrupt.
// - Recent out-of-frame bit covers last window.
// - Status reports Yellow and BLUE_ALARM_STATE window presence.
// - Yellow presence rules per framing format.
// - BLUE_ALARM_STATE present: whole-window OOF, few ones.
`timescale 1ns/1ps
module tai_alarm_integrator #(
    parameter logic [tai_pkg::WIN_W-1:0] WIN_RED_CYC_P =
        tai_pkg::WIN_W'(tai_pkg::WIN_RED_CYC),
    parameter logic [tai_pkg::WIN_W-1:0] WIN_AIS_CYC_P =
        tai_pkg::WIN_W'(tai_pkg::WIN_AIS_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic e1_mode_select_i,
    input wire logic oof_i,
    input wire logic line_bit_valid_i,
    input wire logic line_bit_i,
    input wire logic ch_bit2_valid_i,
    input wire logic ch_bit2_i,
    input wire logic ybit_valid_i,
    input wire logic ybit_i,
    input wire logic esf_yellow_code_i,
    input wire logic [9:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output logic irq_o
);
    import tai_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations.

    logic hold; // Block held in reset by the global E1 select.
    logic [2:0] cfg_r; // ESF, frame mode hi, frame mode lo.
    logic [4:0] ien_r; // Fast, accelerate, three alarm enables.
    logic [2:0] flag_r; // Change flags, alarm order.
    logic [2:0] state; // Live alarm states, alarm order.
    logic [2:0] prev_r; // Alarm states one cycle earlier.
    logic yel_r; // Yellow alarm state.
    logic red_r; // Red alarm state.
    logic ais_r; // BLUE_ALARM_STATE alarm state.
    logic recent_oof_seen_r; // Out-of-frame seen in last 40 ms window.
    logic remote_alarm_seen_r; // Yellow present in last 40 ms window.
    logic blue_alarm_seen_r; // BLUE_ALARM_STATE present in last 60 ms window.
    logic ack_r; // Second cycle of a bus access.
    logic [31:0] rdata_r; // Registered read data.
    logic [WIN_W-1:0] w40_r; // 40 ms window counter.
    logic [WIN_W-1:0] w60_r; // 60 ms window counter.
    logic [WIN_W-1:0] lim40; // Current 40 ms window length.
    logic [WIN_W-1:0] lim60; // Current 60 ms window length.
    logic end40; // Last cycle of a 40 ms window.
    logic end60; // Last cycle of a 60 ms window.
    logic oof_d_r; // Out-of-frame one cycle earlier.
    logic oof_any_r; // Out-of-frame event in this window.
    logic oof_all_r; // Out of frame all through this window.
    logic [7:0] ycnt_r; // Yellow indication count, saturating.
    logic [7:0] ones_r; // Line ones count, saturating.
    logic yel_evt; // Counted Yellow indication this cycle.
    logic yel_win; // Yellow present in ending window.
    logic ais_win; // BLUE_ALARM_STATE present in ending window.
    logic [3:0] ron_r; // Consecutive out-of-frame windows.
    logic [3:0] roff_r; // Consecutive clean 40 ms windows.
    logic [3:0] aoff_r; // Consecutive BLUE_ALARM_STATE-free 60 ms windows.
    logic [3:0] red_on_lim; // Windows needed to assert Red.
    logic [3:0] red_off_lim; // Clean windows needed to clear Red.
    logic [3:0] ais_off_lim; // Clean windows needed to clear BLUE_ALARM_STATE.
    logic req; // Bus access pending.
    logic done; // Bus access completes at this edge.
    logic [7:0] idx; // Register index from the byte address.
    logic isr_rd; // Status register read completes.
    tai_fmt_t fmt; // Decoded framing format.

    // Decode of format bits, used by the logic and by the checks.
    function automatic tai_fmt_t fmt_dec(input logic [2:0] c);
        tai_fmt_t f;
        f = TAI_FMT_RSVD;
        if (c[2]) begin
            // Only 00 is a defined ESF combination.
            f = (c[1:0] == 2'h0) ? TAI_FMT_ESF : TAI_FMT_RSVD;
        end else begin
            case (c[1:0])
                2'h0: f = TAI_FMT_SF;
                2'h1: f = TAI_FMT_T1DM;
                2'h2: f = TAI_FMT_SLC;
                2'h3: f = TAI_FMT_ALT;
                default: f = TAI_FMT_RSVD;
            endcase
        end
        return f;
    endfunction

    // Saturating increment for the per-window Yellow and ones counts.
    function automatic logic [7:0] sat8(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    function automatic logic [3:0] sat4(input logic [3:0] v);
        return (v == 4'hF) ? v : v + 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Mode and window timing.

    // The global E1 select holds every register but the bus handshake and read data at reset value.
    assign hold = e1_mode_select_i;
    assign fmt = fmt_dec(cfg_r);

    // Test speed-up shortens windows; not meant for field use.
    assign lim40 = ien_r[IEN_TEST_ACCELERATE_BIT] ?
        (WIN_RED_CYC_P >> TEST_ACCELERATE_SHIFT) : WIN_RED_CYC_P;
    assign lim60 = ien_r[IEN_TEST_ACCELERATE_BIT] ?
        (WIN_AIS_CYC_P >> TEST_ACCELERATE_SHIFT) : WIN_AIS_CYC_P;
    assign end40 = (w40_r >= lim40 - WIN_W'(1));
    assign end60 = (w60_r >= lim60 - WIN_W'(1));

    // Window counters run freely; compare with >= so that a change
    // of the speed-up bit mid-window cannot strand a counter.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w40_r <= '0;
            w60_r <= '0;
        end else if (hold) begin
            w40_r <= '0;
            w60_r <= '0;
        end else begin
            w40_r <= end40 ? '0 : w40_r + WIN_W'(1);
            w60_r <= end60 ? '0 : w60_r + WIN_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Detection over windows.

    // Yellow source depends on format; alternate T1DM uses Y-bits.
    always_comb begin
        yel_evt = 1'b0;
        case (fmt)
            TAI_FMT_SF, TAI_FMT_SLC: yel_evt = ch_bit2_valid_i & ch_bit2_i;
            TAI_FMT_T1DM, TAI_FMT_ALT: yel_evt = ybit_valid_i & ybit_i;
            TAI_FMT_ESF: yel_evt = esf_yellow_code_i;
            default: yel_evt = 1'b0;
        endcase
    end

    // A reserved format never reports Yellow.
    always_comb begin
        yel_win = 1'b0;
        case (fmt)
            TAI_FMT_SF, TAI_FMT_SLC: yel_win = (ycnt_r <= YEL_SF_MAX);
            TAI_FMT_T1DM, TAI_FMT_ALT: yel_win = (ycnt_r <= YEL_T1DM_MAX);
            TAI_FMT_ESF: yel_win = (ycnt_r >= YEL_ESF_MIN);
            default: yel_win = 1'b0;
        endcase
    end

    // BLUE_ALARM_STATE: out of frame the whole window and few ones on the line.
    assign ais_win = oof_all_r & (ones_r <= AIS_ONES_MAX);

    // Window accumulators; the ending cycle's event counts toward
    // the next window so that no event is dropped at the boundary.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oof_d_r <= 1'b0;
            oof_any_r <= 1'b0;
            ycnt_r <= '0;
        end else if (hold) begin
            oof_d_r <= 1'b0;
            oof_any_r <= 1'b0;
            ycnt_r <= '0;
        end else begin
            oof_d_r <= oof_i;
            if (end40) begin
                oof_any_r <= oof_i & ~oof_d_r;
                ycnt_r <= {7'h00, yel_evt};
            end else begin
                oof_any_r <= oof_any_r | (oof_i & ~oof_d_r);
                ycnt_r <= yel_evt ? sat8(ycnt_r) : ycnt_r;
            end
        end
    end

    // The 60 ms accumulators: persistence of OOF and ones count.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oof_all_r <= 1'b1;
            ones_r <= '0;
        end else if (hold) begin
            oof_all_r <= 1'b1;
            ones_r <= '0;
        end else if (end60) begin
            oof_all_r <= oof_i;
            ones_r <= {7'h00, line_bit_valid_i & line_bit_i};
        end else begin
            oof_all_r <= oof_all_r & oof_i;
            if (line_bit_valid_i && line_bit_i) begin
                ones_r <= sat8(ones_r);
            end
        end
    end

    // Detection status bits update once per window.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            recent_oof_seen_r <= 1'b0;
            remote_alarm_seen_r <= 1'b0;
            blue_alarm_seen_r <= 1'b0;
        end else if (hold) begin
            recent_oof_seen_r <= 1'b0;
            remote_alarm_seen_r <= 1'b0;
            blue_alarm_seen_r <= 1'b0;
        end else begin
            if (end40) begin
                recent_oof_seen_r <= oof_any_r | oof_i;
                remote_alarm_seen_r <= yel_win;
            end
            if (end60) begin
                blue_alarm_seen_r <= ais_win;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm integration.

    // Plain T1DM asserts Red faster; alternate T1DM does not.
    assign red_on_lim = (fmt == TAI_FMT_T1DM) ?
        RED_ON_WIN_T1DM : RED_ON_WIN;
    // Fast mode trades integration margin for quick recovery.
    assign red_off_lim = ien_r[IEN_FAST_BIT] ?
        RED_FAST_WIN : RED_SLOW_WIN;
    assign ais_off_lim = ien_r[IEN_FAST_BIT] ?
        AIS_FAST_WIN : AIS_SLOW_WIN;

    // Red and Yellow step at the end of each 40 ms window.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ron_r <= '0;
            roff_r <= '0;
            red_r <= 1'b0;
            yel_r <= 1'b0;
        end else if (hold) begin
            ron_r <= '0;
            roff_r <= '0;
            red_r <= 1'b0;
            yel_r <= 1'b0;
        end else if (end40) begin
            yel_r <= yel_win;
            if (oof_any_r || oof_i) begin
                // Window held an out-of-frame event.
                roff_r <= '0;
                ron_r <= sat4(ron_r);
                if (sat4(ron_r) >= red_on_lim) begin
                    red_r <= 1'b1;
                end
            end else begin
                // Clean window; count toward deassertion.
                ron_r <= '0;
                roff_r <= sat4(roff_r);
                if (sat4(roff_r) >= red_off_lim) begin
                    red_r <= 1'b0;
                end
            end
        end
    end

    // BLUE_ALARM_STATE steps at the end of each 60 ms window.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aoff_r <= '0;
            ais_r <= 1'b0;
        end else if (hold) begin
            aoff_r <= '0;
            ais_r <= 1'b0;
        end else if (end60) begin
            if (ais_win) begin
                aoff_r <= '0;
                ais_r <= 1'b1;
            end else begin
                // Enough ones or any in-frame time makes the window count toward clearing.
                aoff_r <= sat4(aoff_r);
                if (sat4(aoff_r) >= ais_off_lim) begin
                    ais_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Change flags and interrupt.

    assign state[ALM_YEL] = yel_r;
    assign state[ALM_RED] = red_r;
    assign state[ALM_AIS] = ais_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r <= '0;
        end else if (hold) begin
            prev_r <= '0;
        end else begin
            prev_r <= state;
        end
    end

    // One flag per alarm; a change on the clearing read still sets.
    for (genvar g = 0; g < 3; g++) begin : g_flag
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                flag_r[g] <= 1'b0;
            end else if (hold) begin
                flag_r[g] <= 1'b0;
            end else if (state[g] != prev_r[g]) begin
                flag_r[g] <= 1'b1;
            end else if (isr_rd && rdata_r[ISR_FLAG_LSB + g]) begin
                // Only a flag that the read reported is cleared, so a
                // change landing after the data was taken is kept.
                flag_r[g] <= 1'b0;
            end
        end
    end

    // Each enable gates only its own alarm's flag.
    assign irq_o = |(flag_r & ien_r[2:0]);

    ////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then completion.

    assign req = read_i | write_i;
    assign done = req & ack_r;
    assign waitrequest_o = req & ~ack_r;
    assign idx = address_i[9:2];
    assign isr_rd = done & read_i & (idx == IDX_ISR);
    assign readdata_o = rdata_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Read data is sampled in the wait cycle; unmapped reads give 0.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= '0;
        end else if (read_i && !ack_r) begin
            case (idx)
                IDX_CFG: rdata_r <= {27'h0, cfg_r, 2'h0};
                IDX_IEN: rdata_r <= {27'h0, ien_r};
                IDX_ISR: rdata_r <= {26'h0, flag_r, state};
                IDX_DET: rdata_r <= {29'h0, recent_oof_seen_r, remote_alarm_seen_r, blue_alarm_seen_r};
                default: rdata_r <= '0;
            endcase
        end
    end

    // Writes take effect at completion, low byte lane only.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_r <= CFG_RST;
            ien_r <= IEN_RST;
        end else if (hold) begin
            cfg_r <= CFG_RST;
            ien_r <= IEN_RST;
        end else if (done && write_i && byteenable_i[0]) begin
            if (idx == IDX_CFG) begin
                cfg_r <= writedata_i[CFG_ESF_BIT:CFG_FMS_LO_BIT];
            end
            if (idx == IDX_IEN) begin
                ien_r <= writedata_i[IEN_FAST_BIT:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wait;
        req && waitrequest_o;
    endsequence
    sequence s_isr_read;
        isr_rd && (state == prev_r) &&
            (flag_r == rdata_r[ISR_FLAG_LSB+2:ISR_FLAG_LSB]);
    endsequence

    property p_hold;
        hold |=> (flag_r == 3'h0) && (ien_r == 5'h00) && !red_r;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold did not clear state");

    property p_esf;
        cfg_r == 3'h4 |-> fmt == TAI_FMT_ESF;
    endproperty
    a_esf: assert property (p_esf)
        else $error("ESF not selected");

    property p_alt;
        (fmt == TAI_FMT_ALT) |-> red_on_lim == RED_ON_WIN;
    endproperty
    a_alt: assert property (p_alt)
        else $error("alternate mode uses T1DM Red");

    property p_fast_red;
        end40 && !oof_i && !oof_any_r && ien_r[IEN_FAST_BIT] &&
            (roff_r == RED_FAST_WIN - 4'h1) |=> !red_r;
    endproperty
    a_fast_red: assert property (p_fast_red)
        else $error("Red not cleared in fast mode");

    property p_ais_slow;
        end60 && !ais_win && !ien_r[IEN_FAST_BIT] &&
            (aoff_r == 4'h0) && ais_r |=> ais_r;
    endproperty
    a_ais_slow: assert property (p_ais_slow)
        else $error("BLUE_ALARM_STATE cleared too early");

    property p_irq;
        $rose(flag_r[ALM_RED]) && ien_r[ALM_RED] |-> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing");

    property p_clear;
        s_isr_read |=> flag_r == 3'h0 ##1 (flag_r != 3'h0 || !irq_o);
    endproperty
    a_clear: assert property (p_clear)
        else $error("status read did not clear");

    // A flag raised after the read data was taken must not be lost.
    property p_keep;
        isr_rd && (flag_r != rdata_r[ISR_FLAG_LSB+2:ISR_FLAG_LSB]) |=>
            flag_r != 3'h0;
    endproperty
    a_keep: assert property (p_keep)
        else $error("unreported change flag was lost");

    property p_recent_oof_seen;
        end40 && oof_any_r |=> recent_oof_seen_r;
    endproperty
    a_recent_oof_seen: assert property (p_recent_oof_seen)
        else $error("recent out-of-frame missed");

    property p_blue_alarm_seen;
        end60 && !oof_all_r |=> !blue_alarm_seen_r;
    endproperty
    a_blue_alarm_seen: assert property (p_blue_alarm_seen)
        else $error("BLUE_ALARM_STATE seen while in frame");

    property p_bus;
        s_wait |=> !waitrequest_o;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus access not answered");

endmodule

// File: tai_framer_model.sv
// Purpose: Behavioural receive framer that feeds the alarm integrator.
// Assumes: Shares the integrator clock; strobes are periodic.
// Notes: Request inputs pick out-of-frame, Yellow or BLUE_ALARM_STATE patterns.
`timescale 1ns/1ps
module tai_framer_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic lose_i,
    input wire logic ylw_i,
    input wire logic ais_i,
    output logic oof_o,
    output logic line_bit_valid_o,
    output logic line_bit_o,
    output logic ch_bit2_valid_o,
    output logic ch_bit2_o,
    output logic ybit_valid_o,
    output logic ybit_o,
    output logic esf_yellow_code_o
);
    logic [2:0] ph_r; // Strobe phase.
    // Free-running phase; strobes land every fourth or eighth cycle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_r <= 3'h0;
        end else begin
            ph_r <= ph_r + 3'h1;
        end
    end
    // BLUE_ALARM_STATE also means lost framing, so the framer reports it out of frame.
    assign oof_o = lose_i | ais_i;
    assign line_bit_valid_o = 1'h1;
    // Three ones in four keep the count well above the BLUE_ALARM_STATE limit.
    assign line_bit_o = ~ais_i & (ph_r[0] | ph_r[1]);
    assign ch_bit2_valid_o = (ph_r[1:0] == 2'h0);
    assign ch_bit2_o = ~ylw_i;
    assign ybit_valid_o = (ph_r == 3'h0);
    assign ybit_o = ~ylw_i;
    assign esf_yellow_code_o = ylw_i & (ph_r == 3'h0);
endmodule

// File: tai_pkg.sv
// Purpose: Shared constants for the T1 alarm integrator.
// Assumes: 100 MHz clock; 32-bit Avalon-MM register slave.
// Notes: Offsets are register indices; byte address is four times.
package tai_pkg;
    // Clock rate, used to turn times into cycle counts.
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // Integration windows, in milliseconds.
    localparam int unsigned WIN_RED_MS = 40;
    localparam int unsigned WIN_AIS_MS = 60;
    localparam int unsigned WIN_RED_CYC = WIN_RED_MS * CYC_PER_MS;
    localparam int unsigned WIN_AIS_CYC = WIN_AIS_MS * CYC_PER_MS;
    localparam int WIN_W = 23;
    // Test speed-up divides both windows by two to this power.
    localparam int TEST_ACCELERATE_SHIFT = 8;
    // Fast deassertion limits, in milliseconds.
    localparam int unsigned FAST_RED_MS = 120;
    localparam int unsigned FAST_AIS_MS = 180;
    // Whole clean windows that fit inside a limit with a partial one.
    localparam logic [3:0] RED_FAST_WIN = 4'(FAST_RED_MS / WIN_RED_MS - 1);
    localparam logic [3:0] AIS_FAST_WIN = 4'(FAST_AIS_MS / WIN_AIS_MS - 1);
    // Normal, slower deassertion, in clean windows.
    localparam logic [3:0] RED_SLOW_WIN = 4'h6;
    localparam logic [3:0] AIS_SLOW_WIN = 4'h6;
    // Consecutive out-of-frame windows before Red asserts.
    localparam logic [3:0] RED_ON_WIN = 4'h2;
    localparam logic [3:0] RED_ON_WIN_T1DM = 4'h1;
    // Detection thresholds per window.
    localparam logic [7:0] YEL_SF_MAX = 8'h10;
    localparam logic [7:0] YEL_T1DM_MAX = 8'h04;
    localparam logic [7:0] YEL_ESF_MIN = 8'h08;
    localparam logic [7:0] AIS_ONES_MAX = 8'h7E;
    // Register indices.
    localparam logic [7:0] IDX_CFG = 8'h60;
    localparam logic [7:0] IDX_IEN = 8'h61;
    localparam logic [7:0] IDX_ISR = 8'h62;
    localparam logic [7:0] IDX_DET = 8'h63;
    // Field positions of the configuration register.
    localparam int CFG_ESF_BIT = 4;
    localparam int CFG_FMS_HI_BIT = 3;
    localparam int CFG_FMS_LO_BIT = 2;
    // Field positions of the enable register.
    localparam int IEN_FAST_BIT = 4;
    localparam int IEN_TEST_ACCELERATE_BIT = 3;
    // Alarm order in the flag, state and enable groups: 2 Yellow, 1 Red, 0 BLUE_ALARM_STATE.
    localparam int ALM_YEL = 2;
    localparam int ALM_RED = 1;
    localparam int ALM_AIS = 0;
    localparam int ISR_FLAG_LSB = 3;
    // Reset values.
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [4:0] IEN_RST = 5'h00;
    // Framing formats, one-hot.
    typedef enum logic [5:0] {
        TAI_FMT_SF = 6'h01,
        TAI_FMT_T1DM = 6'h02,
        TAI_FMT_SLC = 6'h04,
        TAI_FMT_ALT = 6'h08,
        TAI_FMT_ESF = 6'h10,
        TAI_FMT_RSVD = 6'h20
    } tai_fmt_t;
endpackage

// File: testbench.sv
// Purpose: Self-checking bench for the T1 alarm integrator.
// Assumes: Short windows of 200 and 300 cycles.
// Notes: Reads queue expectations; a monitor pops them on completion.
`timescale 1ns/1ps
module testbench;
    import tai_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic e1 = 1'h0;
    logic lose = 1'h0;
    logic ylw = 1'h0;
    logic blue_alarm_state = 1'h0;
    logic oof, lv, lb, cv, cb, yv, yb, esf;
    logic [9:0] address = 10'h000;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wreq, irq;
    logic [31:0] exp_q[$]; // Expected read data, oldest first.
    logic [31:0] seed = 32'h2C;
    logic [7:0] fmt [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    int miscompares = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    tai_framer_model far (.clk_i(clk), .rst_n_i(rst_n), .lose_i(lose),
        .ylw_i(ylw), .ais_i(blue_alarm_state), .oof_o(oof), .line_bit_valid_o(lv),
        .line_bit_o(lb), .ch_bit2_valid_o(cv), .ch_bit2_o(cb),
        .ybit_valid_o(yv), .ybit_o(yb), .esf_yellow_code_o(esf));
    tai_alarm_integrator #(.WIN_RED_CYC_P(23'h0000C8),
        .WIN_AIS_CYC_P(23'h00012C)) uut (.clk_i(clk), .rst_n_i(rst_n),
        .e1_mode_select_i(e1), .oof_i(oof), .line_bit_valid_i(lv),
        .line_bit_i(lb), .ch_bit2_valid_i(cv), .ch_bit2_i(cb),
        .ybit_valid_i(yv), .ybit_i(yb), .esf_yellow_code_i(esf),
        .address_i(address), .read_i(read), .write_i(write),
        .writedata_i(wdata), .byteenable_i(4'hF), .readdata_o(rdata),
        .waitrequest_o(wreq), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic finish_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One Avalon transfer; the request holds until waitrequest is low.
    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= {idx, 2'h0};
        read <= ~wr;
        write <= wr;
        wdata <= d;
        // Waitrequest is looked at on the rising edge itself.
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'h0 && n < 50);
        if (wreq !== 1'h0) begin
            miscompares++;
            $display("[ERR] waitrequest expected 0 seen 1");
            finish_test();
        end
        read <= 1'h0;
        write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(idx, 1'h0, 32'h0);
    endtask
    // Waits a bounded time for the interrupt to reach a level.
    task automatic wait_irq(input logic e, input int max);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (irq !== e && n < max);
        cmp("irq", {31'h0, e}, {31'h0, irq});
        if (irq !== e) finish_test();
    endtask
    // Each completed read takes the oldest expectation off the queue.
    // Taken at the rising edge that completes the read.
    always @(posedge clk) begin
        if (read === 1'h1 && wreq === 1'h0) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("[ERR] readdata expected none seen %h", rdata);
            end else begin
                cmp("readdata", exp_q.pop_front(), rdata);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int k;
        logic [31:0] v;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rd(IDX_CFG, 32'h0);
        rd(IDX_IEN, 32'h0);
        rd(IDX_ISR, 32'h0);
        rd(IDX_DET, 32'h0);
        rd(8'h64, 32'h0);
        // Test speed-up stays off whatever the random draw says.
        for (i = 0; i < 4; i++) begin
            v = xs() & 32'hFFFFFFF7;
            bus(IDX_IEN, 1'h1, v);
            rd(IDX_IEN, v & 32'h17);
        end
        bus(IDX_IEN, 1'h1, 32'h7);
        e1 <= 1'h1;
        repeat (2) @(posedge clk);
        e1 <= 1'h0;
        rd(IDX_IEN, 32'h0);
        // Yellow on and off in every legal format.
        bus(IDX_IEN, 1'h1, 32'h4);
        for (i = 0; i < 5; i++) begin
            bus(IDX_CFG, 1'h1, {24'h0, fmt[i]});
            ylw <= 1'h1;
            wait_irq(1'h1, 450);
            rd(IDX_DET, 32'h2);
            rd(IDX_ISR, 32'h24);
            ylw <= 1'h0;
            wait_irq(1'h1, 450);
            rd(IDX_ISR, 32'h20);
        end
        // Red with fast clearing.
        bus(IDX_CFG, 1'h1, 32'h0);
        bus(IDX_IEN, 1'h1, 32'h12);
        lose <= 1'h1;
        wait_irq(1'h1, 700);
        rd(IDX_ISR, 32'h12);
        wait_irq(1'h0, 2);
        rd(IDX_DET, 32'h4);
        lose <= 1'h0;
        wait_irq(1'h1, 610);
        rd(IDX_ISR, 32'h10);
        // Red with normal clearing must outlast the fast limit; plain
        // T1DM asserts Red after a single out-of-frame window.
        bus(IDX_CFG, 1'h1, 32'h4);
        bus(IDX_IEN, 1'h1, 32'h2);
        lose <= 1'h1;
        wait_irq(1'h1, 210);
        rd(IDX_ISR, 32'h12);
        lose <= 1'h0;
        k = 0;
        repeat (590) begin
            @(negedge clk);
            if (irq !== 1'h0) k++;
        end
        cmp("irq_quiet", 32'h0, k);
        wait_irq(1'h1, 1000);
        rd(IDX_ISR, 32'h10);
        rd(IDX_DET, 32'h0);
        // BLUE_ALARM_STATE with fast clearing; Red follows the same loss of frame.
        bus(IDX_IEN, 1'h1, 32'h11);
        blue_alarm_state <= 1'h1;
        wait_irq(1'h1, 700);
        repeat (700) @(negedge clk);
        rd(IDX_DET, 32'h5);
        rd(IDX_ISR, 32'h1B);
        blue_alarm_state <= 1'h0;
        wait_irq(1'h1, 910);
        repeat (610) @(negedge clk);
        rd(IDX_ISR, 32'h18);
        finish_test();
    end
endmodule
